// *** bench/fsg_frame_sync_properties.sv ***
`timescale 1ns/100ps
// ****************
// Checker on the top ports
// ****************
module fsg_frame_sync_checker (
   // Clock and reset
   input wire logic                         clk,
   input wire logic                         sys_rst,
   // Register access
   input wire logic [7:0]                   reg_addr,
   input wire logic [7:0]                   reg_wdata,
   input wire logic                         reg_wr,
   input wire logic                         reg_rd,
   input wire logic [7:0]                   reg_rdata,
   // Pins
   input wire logic [fsg_pkg::NUM_GPIO-1:0] gpio_in,
   input wire logic [fsg_pkg::GP_BITS-1:0]  bc_gp_port0,
   input wire logic [fsg_pkg::GP_BITS-1:0]  bc_gp_port1
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (sys_rst);
   // Shadows of bus writes and per-port hold counters; ports only, so the state is rebuilt here
   logic [7:0]  shd_r [24:28];
   logic [7:0]  psel_r;
   logic [7:0]  route0_r;
   logic [11:0] hold0_r;
   logic [11:0] hold1_r;
   wire         in_blk = reg_addr >= 8'h18 && reg_addr <= 8'h1C;
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         shd_r <= '{default: 8'h00};
         psel_r <= fsg_pkg::PSEL_RESET;
         route0_r <= 8'h00;
         hold0_r <= 12'h000;
         hold1_r <= 12'h000;
      end else begin
         if (reg_wr && in_blk) shd_r[reg_addr] <= reg_wdata;
         if (reg_wr && reg_addr == 8'h4C) psel_r <= reg_wdata;
         if (reg_wr && reg_addr == 8'h6E && psel_r[0]) route0_r <= reg_wdata;
         hold0_r <= $changed(bc_gp_port0) ? 12'h000 : hold0_r + {11'h000, ~&hold0_r};
         hold1_r <= $changed(bc_gp_port1) ? 12'h000 : hold1_r + {11'h000, ~&hold1_r};
      end
   end
   AST_RESET_OUT: assert property (disable iff (1'b0) sys_rst |=>
      bc_gp_port0 == 2'h0 && bc_gp_port1 == 2'h0 && reg_rdata == 8'h00)
      else $error("Outputs not cleared by reset");
   AST_RD_REGS: assert property (reg_rd && !reg_wr && in_blk |=>
      reg_rdata == $past(shd_r[reg_addr])) else $error("Period or control readback wrong");
   AST_RD_ENABLE: assert property (reg_wr && reg_addr == 8'h18 && reg_wdata[0]
      ##1 !reg_wr ##1 reg_rd && reg_addr == 8'h18 |=> reg_rdata[0])
      else $error("Enable bit not read back");
   AST_RD_UNMAPPED: assert property (reg_rd && reg_addr == 8'h30 |=>
      reg_rdata == 8'h00) else $error("Unmapped read not zero");
   AST_RDATA_HOLD: assert property (!reg_rd |=> $stable(reg_rdata))
      else $error("Read data moved without a read");
   AST_HOLD_P0: assert property ($changed(bc_gp_port0) |-> hold0_r >= 12'h03A)
      else $error("Port 0 bits changed inside a frame");
   AST_HOLD_P1: assert property ($changed(bc_gp_port1) |-> hold1_r >= 12'h03A)
      else $error("Port 1 bits changed inside a frame");
   AST_ROUTE_PAIR: assert property (route0_r == 8'hAA && $past(route0_r, 1300) == 8'hAA
      |-> bc_gp_port0[1] == bc_gp_port0[0]) else $error("Routed bits differ");
   COV_GEN_ON: cover property (reg_wr && reg_addr == 8'h18 && reg_wdata[0]);
   COV_P0_EDGE: cover property ($changed(bc_gp_port0));
   COV_P1_EDGE: cover property ($changed(bc_gp_port1));
endmodule : fsg_frame_sync_checker

bind fsg_frame_sync fsg_frame_sync_checker u_chk (.clk(clk), .sys_rst(sys_rst),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .gpio_in(gpio_in), .bc_gp_port0(bc_gp_port0),
   .bc_gp_port1(bc_gp_port1));

// *** bench/fsg_ser_model.sv ***
`timescale 1ns/100ps
// ****************
// Camera-side receiver of one back channel
// ****************
module fsg_ser_model (
   // Clock
   input  wire logic       clk,
   // Back-channel bits
   input  wire logic [1:0] gp,
   // Measured phase lengths in clock cycles, and the count of edges
   output int              hi_len,
   output int              lo_len,
   output int              edges
);
   int   run;
   logic last;
   initial begin
      run = 0;
      last = 1'b0;
      edges = 0;
   end
   // Only bit 0 is timed; the checker ties bit 1 to it on port 0 only, while its routing holds 8'hAA
   always @(posedge clk) begin
      if (gp[0] !== last) begin
         if (last === 1'b1) hi_len = run;
         else lo_len = run;
         edges = edges + 1;
         run = 1;
      end else begin
         run = run + 1;
      end
      last = gp[0];
   end
endmodule : fsg_ser_model

// *** bench/tb_top.sv ***
`timescale 1ns/100ps
module tb_top;
   // ****************
   // Signals
   // ****************
   localparam int                F = fsg_pkg::FRAME_CYC_50M;
   logic                         clk, sys_rst, reg_wr, reg_rd;
   logic [7:0]                   reg_addr, reg_wdata, reg_rdata;
   logic [fsg_pkg::NUM_GPIO-1:0] gpio_in;
   logic [1:0]                   bc_gp_port0, bc_gp_port1;
   int                           hi0, lo0, ed0, hi1, lo1, ed1;
   int                           err_count, total_checks, cyc, n;
   logic [7:0] ra [9] = '{8'h18, 8'h19, 8'h1A, 8'h1B, 8'h1C, 8'h4C, 8'h58, 8'h6E, 8'h30};
   logic [7:0] rv [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00};
   fsg_frame_sync dut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .gpio_in(gpio_in), .bc_gp_port0(bc_gp_port0), .bc_gp_port1(bc_gp_port1));
   fsg_ser_model u_ser0 (.clk(clk), .gp(bc_gp_port0), .hi_len(hi0), .lo_len(lo0), .edges(ed0));
   fsg_ser_model u_ser1 (.clk(clk), .gp(bc_gp_port1), .hi_len(hi1), .lo_len(lo1), .edges(ed1));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Whole run needs about 11000 cycles; the ceiling leaves room
   always @(posedge clk) begin
      cyc++;
      if (cyc == 30000) begin
         err_count++;
         end_sim();
      end
   end
   // ****************
   // Tasks
   // ****************
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge clk);
      reg_wr = 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(negedge clk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge clk);
      reg_rd = 1'b0;
      chk({8'h00, reg_rdata}, {8'h00, e});
   endtask : rd
   task automatic idle(input int c);
      repeat (c) @(negedge clk);
   endtask : idle
   task automatic wait0(input logic v);
      n = 0;
      while (bc_gp_port0[0] !== v && n < 1400) begin
         @(negedge clk);
         n++;
      end
   endtask : wait0
   task automatic end_sim();
      $display("Checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : end_sim
   // ****************
   // Tests
   // ****************
   initial begin
      sys_rst = 1'b1;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      gpio_in = '0;
      repeat (2) @(posedge clk);
      @(negedge clk);
      sys_rst = 1'b0;
      wr(8'h30, 8'h5A);
      for (int i = 0; i < 9; i++) rd(ra[i], rv[i]);
      $display("Test reset values finished");
      wr(8'h4C, 8'h03);
      wr(8'h58, 8'h06);
      wr(8'h6E, 8'hAA);
      wr(8'h4C, 8'h12);
      rd(8'h6E, 8'hAA);
      rd(8'h58, 8'h06);
      $display("Test routing finished");
      // Bench clock stands for the nominal reference, so counts go in unscaled
      wr(8'h1A, 8'h02);
      wr(8'h1C, 8'h04);
      rd(8'h1C, 8'h04);
      wr(8'h18, 8'h05);
      rd(8'h18, 8'h05);
      wait0(1'b1);
      chk(16'(n > 70), 16'h0000);
      idle(1200);
      chk(16'(hi0), 16'(3 * F));
      chk(16'(lo0), 16'(5 * F));
      chk(16'(lo1), 16'(5 * F));
      chk({14'h0000, bc_gp_port0}, {14'h0000, bc_gp_port1});
      wr(8'h18, 8'h04);
      idle(100);
      n = ed0;
      idle(600);
      chk(16'(ed0 - n), 16'h0000);
      chk({14'h0000, bc_gp_port0}, 16'h0003);
      wr(8'h18, 8'h03);
      idle(1200);
      chk(16'(lo0), 16'(3 * F));
      chk(16'(ed0 - n > 4), 16'h0001);
      wr(8'h4C, 8'h02);
      wr(8'h58, 8'h00);
      wr(8'h1A, 8'h00);
      wr(8'h18, 8'h13);
      idle(5000);
      chk(16'(hi0), 16'(fsg_pkg::FRAME_CYC_2M5));
      chk(16'(hi1), 16'(fsg_pkg::FRAME_CYC_2M5));
      // Settle port 1 first: the faster rate cuts its running frame short
      wr(8'h18, 8'h00);
      idle(1300);
      chk({14'h0000, bc_gp_port1}, 16'h0000);
      wr(8'h58, 8'h06);
      $display("Test generator finished");
      for (int k = 0; k < 7; k++) begin
         gpio_in = '0;
         wr(8'h18, {4'(k + 8), 4'h0});
         wait0(1'b0);
         gpio_in = 7'(1 << k);
         wait0(1'b1);
         chk(16'(n > 62), 16'h0000);
         idle(62);
         chk({14'h0000, bc_gp_port1}, 16'h0003);
         gpio_in = ~7'(1 << k);
         wait0(1'b0);
         chk(16'(n > 62), 16'h0000);
      end
      wr(8'h4C, 8'h01);
      wr(8'h6E, 8'h1A);
      rd(8'h6E, 8'h1A);
      idle(62);
      chk({14'h0000, bc_gp_port0}, 16'h0002);
      chk({14'h0000, bc_gp_port1}, 16'h0000);
      $display("Test external relay finished");
      end_sim();
   end
endmodule : tb_top

// *** hdl/fsg_frame_sync.sv ***
`timescale 1ns/100ps
module fsg_frame_sync (
   // Clock and reset
   input  wire logic                          clk,
   input  wire logic                          sys_rst,
   // Register access from the control interface
   input  wire logic [7:0]                    reg_addr,
   input  wire logic [7:0]                    reg_wdata,
   input  wire logic                          reg_wr,
   input  wire logic                          reg_rd,
   output logic      [7:0]                    reg_rdata,
   // External general-purpose pins
   input  wire logic [fsg_pkg::NUM_GPIO-1:0]  gpio_in,
   // Back-channel general-purpose bits
   output logic      [fsg_pkg::GP_BITS-1:0]   bc_gp_port0,
   output logic      [fsg_pkg::GP_BITS-1:0]   bc_gp_port1
);

   // ********************************************************
   // Common registers
   // ********************************************************
   logic [7:0]                   sync_control_r;
   logic [7:0]                   high_upper_r;
   logic [7:0]                   high_lower_r;
   logic [7:0]                   low_upper_r;
   logic [7:0]                   low_lower_r;
   logic [7:0]                   port_select_r;
   logic [7:0]                   rdata_r;
   logic [7:0]                   rdata_nxt;

   logic                         wr_ctl;
   logic                         wr_hu;
   logic                         wr_hl;
   logic                         wr_lu;
   logic                         wr_ll;
   logic                         wr_psel;
   logic                         wr_rate;
   logic                         wr_route;

   assign wr_ctl   = reg_wr && (reg_addr == fsg_pkg::ADDR_SYNC_CONTROL);
   assign wr_hu    = reg_wr && (reg_addr == fsg_pkg::ADDR_HIGH_UPPER);
   assign wr_hl    = reg_wr && (reg_addr == fsg_pkg::ADDR_HIGH_LOWER);
   assign wr_lu    = reg_wr && (reg_addr == fsg_pkg::ADDR_LOW_UPPER);
   assign wr_ll    = reg_wr && (reg_addr == fsg_pkg::ADDR_LOW_LOWER);
   assign wr_psel  = reg_wr && (reg_addr == fsg_pkg::ADDR_PORT_SELECT);
   assign wr_rate  = reg_wr && (reg_addr == fsg_pkg::ADDR_RATE_SELECT);
   assign wr_route = reg_wr && (reg_addr == fsg_pkg::ADDR_ROUTING_0);

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         sync_control_r <= fsg_pkg::CTL_RESET;
         high_upper_r   <= fsg_pkg::PERIOD_BYTE_RESET;
         high_lower_r   <= fsg_pkg::PERIOD_BYTE_RESET;
         low_upper_r    <= fsg_pkg::PERIOD_BYTE_RESET;
         low_lower_r    <= fsg_pkg::PERIOD_BYTE_RESET;
         port_select_r  <= fsg_pkg::PSEL_RESET;
      end else begin
         if (wr_ctl) begin
            sync_control_r <= reg_wdata;
         end
         if (wr_hu) begin
            high_upper_r <= reg_wdata;
         end
         if (wr_hl) begin
            high_lower_r <= reg_wdata;
         end
         if (wr_lu) begin
            low_upper_r <= reg_wdata;
         end
         if (wr_ll) begin
            low_lower_r <= reg_wdata;
         end
         if (wr_psel) begin
            port_select_r <= reg_wdata;
         end
      end
   end

   // ********************************************************
   // Control fields
   // ********************************************************
   logic        gen_enable;
   logic        duty_mode_select;
   logic        initial_level;
   logic [3:0]  sync_source_select;
   logic [15:0] high_period_count;
   logic [15:0] low_period_count;

   assign gen_enable         = sync_control_r[fsg_pkg::CTL_GEN_EN_BIT];
   assign duty_mode_select   = sync_control_r[fsg_pkg::CTL_DUTY_BIT];
   assign initial_level      = sync_control_r[fsg_pkg::CTL_INIT_BIT];
   assign sync_source_select = sync_control_r[fsg_pkg::CTL_SRC_LSB +: 4];
   assign high_period_count  = {high_upper_r, high_lower_r};
   assign low_period_count   = {low_upper_r, low_lower_r};

   // ********************************************************
   // Per-port rate, routing, tick and back-channel bits
   // ********************************************************
   logic [2:0]                       rate_sel_r [fsg_pkg::NUM_PORTS];
   logic [7:0]                       routing_r  [fsg_pkg::NUM_PORTS];
   logic [fsg_pkg::NUM_PORTS-1:0]    port_tick;
   logic [fsg_pkg::GP_BITS-1:0]      bc_gp_r    [fsg_pkg::NUM_PORTS];
   logic                             frame_sync_a_r;

   genvar p;
   genvar b;
   generate
      for (p = 0; p < fsg_pkg::NUM_PORTS; p++) begin : g_port
         always_ff @(posedge clk) begin
            if (sys_rst) begin
               rate_sel_r[p] <= fsg_pkg::RATE_RESET;
               routing_r[p]  <= fsg_pkg::ROUTE_RESET;
            end else begin
               if (wr_rate && port_select_r[p]) begin
                  rate_sel_r[p] <= reg_wdata[2:0];
               end
               if (wr_route && port_select_r[p]) begin
                  routing_r[p] <= reg_wdata;
               end
            end
         end

         fsg_tick_gen u_tick (
            .clk      (clk),
            .sys_rst  (sys_rst),
            .rate_sel (rate_sel_r[p]),
            .tick     (port_tick[p])
         );

         for (b = 0; b < fsg_pkg::GP_BITS; b++) begin : g_bit
            logic [3:0] route_code;
            logic       bit_value;
            assign route_code = routing_r[p][4*b +: 4];
            assign bit_value  = (route_code == fsg_pkg::ROUTE_FRAME_SYNC) ? frame_sync_a_r :
                                (route_code == fsg_pkg::ROUTE_DRIVE_HIGH);
            // Bits change only at a frame boundary, as the back channel sends them
            always_ff @(posedge clk) begin
               if (sys_rst) begin
                  bc_gp_r[p][b] <= 1'b0;
               end else if (port_tick[p]) begin
                  bc_gp_r[p][b] <= bit_value;
               end
            end
         end
      end
   endgenerate

   assign bc_gp_port0 = bc_gp_r[0];
   assign bc_gp_port1 = bc_gp_r[1];

   // ********************************************************
   // Internal generator
   // ********************************************************
   fsg_pkg::fsg_phase_type phase_r;
   fsg_pkg::fsg_phase_type phase_nxt;
   logic [15:0]            phase_cnt_r;
   logic [15:0]            phase_cnt_nxt;
   logic [15:0]            phase_limit;
   logic                   gen_tick;
   logic                   gen_level;

   // Only the port 1 code moves the tick off port 0
   assign gen_tick    = (sync_source_select == fsg_pkg::SRC_TICK_PORT1) ?
                        port_tick[1] : port_tick[0];
   // In 50/50 mode both phases use the high count
   assign phase_limit = (duty_mode_select || (phase_r == fsg_pkg::GEN_HIGH)) ?
                        high_period_count : low_period_count;
   assign gen_level   = (phase_r == fsg_pkg::GEN_OFF) ? initial_level :
                        (phase_r == fsg_pkg::GEN_HIGH);

   always_comb begin
      phase_nxt     = phase_r;
      phase_cnt_nxt = phase_cnt_r;
      if (!gen_enable) begin
         phase_nxt     = fsg_pkg::GEN_OFF;
         phase_cnt_nxt = '0;
      end else begin
         unique case (phase_r)
            fsg_pkg::GEN_OFF: begin
               phase_nxt     = initial_level ? fsg_pkg::GEN_HIGH : fsg_pkg::GEN_LOW;
               phase_cnt_nxt = '0;
            end
            fsg_pkg::GEN_HIGH, fsg_pkg::GEN_LOW: begin
               if (gen_tick) begin
                  if (phase_cnt_r >= phase_limit) begin
                     phase_nxt     = (phase_r == fsg_pkg::GEN_HIGH) ?
                                     fsg_pkg::GEN_LOW : fsg_pkg::GEN_HIGH;
                     phase_cnt_nxt = '0;
                  end else begin
                     phase_cnt_nxt = phase_cnt_r + 16'h0001;
                  end
               end
            end
            default: begin
               phase_nxt     = fsg_pkg::GEN_OFF;
               phase_cnt_nxt = '0;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         phase_r     <= fsg_pkg::GEN_OFF;
         phase_cnt_r <= '0;
      end else begin
         phase_r     <= phase_nxt;
         phase_cnt_r <= phase_cnt_nxt;
      end
   end

   // ********************************************************
   // Source selection
   // ********************************************************
   logic ext_valid;
   logic ext_level;
   logic sync_nxt;

   assign ext_valid = (sync_source_select >= fsg_pkg::SRC_EXT_FIRST) &&
                      (sync_source_select <= fsg_pkg::SRC_EXT_LAST);
   assign ext_level = ext_valid && gpio_in[sync_source_select[2:0]];
   // Generator wins when enabled; with no pin chosen its idle level shows
   assign sync_nxt  = (gen_enable || !ext_valid) ? gen_level : ext_level;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         frame_sync_a_r <= 1'b0;
      end else begin
         frame_sync_a_r <= sync_nxt;
      end
   end

   // ********************************************************
   // Read back
   // ********************************************************
   logic       rd_port;

   assign rd_port   = port_select_r[fsg_pkg::PSEL_READ_BIT];
   assign rdata_nxt =
      (reg_addr == fsg_pkg::ADDR_SYNC_CONTROL) ? sync_control_r :
      (reg_addr == fsg_pkg::ADDR_HIGH_UPPER)   ? high_upper_r   :
      (reg_addr == fsg_pkg::ADDR_HIGH_LOWER)   ? high_lower_r   :
      (reg_addr == fsg_pkg::ADDR_LOW_UPPER)    ? low_upper_r    :
      (reg_addr == fsg_pkg::ADDR_LOW_LOWER)    ? low_lower_r    :
      (reg_addr == fsg_pkg::ADDR_PORT_SELECT)  ? port_select_r  :
      (reg_addr == fsg_pkg::ADDR_RATE_SELECT)  ? {5'h00, rate_sel_r[rd_port]} :
      (reg_addr == fsg_pkg::ADDR_ROUTING_0)    ? routing_r[rd_port] :
      8'h00;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rdata_r <= 8'h00;
      end else if (reg_rd) begin
         rdata_r <= rdata_nxt;
      end
   end

   assign reg_rdata = rdata_r;

endmodule : fsg_frame_sync

// *** hdl/fsg_tick_gen.sv ***
`timescale 1ns/100ps
module fsg_tick_gen (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       sys_rst,
   // Back-channel rate
   input  wire logic [2:0] rate_sel,
   // One pulse per back-channel frame
   output logic            tick
);

   logic [fsg_pkg::TICK_CNT_W-1:0] cnt_r;
   logic [fsg_pkg::TICK_CNT_W-1:0] cnt_nxt;
   logic [fsg_pkg::TICK_CNT_W-1:0] last_cnt;
   logic                           tick_r;
   logic                           at_last;

   // Rates other than the fast code fall back to the slowest frame
   assign last_cnt = (rate_sel == fsg_pkg::RATE_50M) ?
                     fsg_pkg::TICK_CNT_W'(fsg_pkg::FRAME_CYC_50M - 1) :
                     fsg_pkg::TICK_CNT_W'(fsg_pkg::FRAME_CYC_2M5 - 1);
   assign at_last  = (cnt_r >= last_cnt);
   assign cnt_nxt  = at_last ? '0 : cnt_r + 1'b1;
   assign tick     = tick_r;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cnt_r  <= '0;
         tick_r <= 1'b0;
      end else begin
         cnt_r  <= cnt_nxt;
         tick_r <= at_last;
      end
   end

endmodule : fsg_tick_gen

// *** shared/fsg_pkg.sv ***
package fsg_pkg;

   // ********************************************************
   // Register offsets
   // ********************************************************
   localparam logic [7:0] ADDR_SYNC_CONTROL  = 8'h18;
   localparam logic [7:0] ADDR_HIGH_UPPER    = 8'h19;
   localparam logic [7:0] ADDR_HIGH_LOWER    = 8'h1A;
   localparam logic [7:0] ADDR_LOW_UPPER     = 8'h1B;
   localparam logic [7:0] ADDR_LOW_LOWER     = 8'h1C;
   localparam logic [7:0] ADDR_PORT_SELECT   = 8'h4C;
   localparam logic [7:0] ADDR_RATE_SELECT   = 8'h58;
   localparam logic [7:0] ADDR_ROUTING_0     = 8'h6E;

   // ********************************************************
   // Field positions and codes
   // ********************************************************
   localparam int         CTL_GEN_EN_BIT     = 0;
   localparam int         CTL_DUTY_BIT       = 1;
   localparam int         CTL_INIT_BIT       = 2;
   localparam int         CTL_SRC_LSB        = 4;
   localparam int         PSEL_READ_BIT      = 4;
   localparam logic [3:0] SRC_TICK_PORT1     = 4'h1;
   localparam logic [3:0] SRC_EXT_FIRST      = 4'h8;
   localparam logic [3:0] SRC_EXT_LAST       = 4'hE;
   localparam logic [2:0] RATE_50M           = 3'h6;
   localparam logic [3:0] ROUTE_DRIVE_HIGH   = 4'h1;
   localparam logic [3:0] ROUTE_FRAME_SYNC   = 4'hA;

   // ********************************************************
   // Values after reset
   // ********************************************************
   localparam logic [7:0] CTL_RESET          = 8'h00;
   localparam logic [7:0] PERIOD_BYTE_RESET  = 8'h00;
   localparam logic [7:0] PSEL_RESET         = 8'h01;
   localparam logic [2:0] RATE_RESET         = 3'h0;
   localparam logic [7:0] ROUTE_RESET        = 8'h00;

   // ********************************************************
   // Sizes and timing
   // ********************************************************
   localparam int         NUM_PORTS          = 2;
   localparam int         NUM_GPIO           = 7;
   localparam int         GP_BITS            = 2;
   localparam int         CLK_PERIOD_NS      = 10;
   localparam int         FRAME_BITS         = 30;
   localparam int         BIT_NS_50M         = 20;
   localparam int         BIT_NS_2M5         = 400;
   localparam int         FRAME_CYC_50M      = FRAME_BITS * BIT_NS_50M / CLK_PERIOD_NS;
   localparam int         FRAME_CYC_2M5      = FRAME_BITS * BIT_NS_2M5 / CLK_PERIOD_NS;
   localparam int         TICK_CNT_W         = 11;

   typedef enum logic [1:0] {
      GEN_OFF,
      GEN_HIGH,
      GEN_LOW
   } fsg_phase_type;

endpackage : fsg_pkg
